/* design/pwmc_config_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_cfg.svh"
module pwmc_config_reg #(
	parameter int WAKE_DET_CYC = `PWMC_WAKE_DET_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [4:0]  regAddr,
	input  wire logic        regWrite,
	input  wire logic [15:0] regWdata,
	output logic      [15:0] regRdata,
	input  wire logic        strapRole,
	input  wire logic        strapWakeEn,
	input  wire logic [1:0]  strapIface,
	input  wire logic        localWakePin,
	input  wire logic        remoteWakeRx,
	input  wire logic        sleepReqMode,
	input  wire logic        dataActivity,
	input  wire logic        peerSleepConfirm,
	output logic             roleMaster,
	output logic [1:0]       hostIfaceSel,
	output logic             refClkIsOutput,
	output logic             driveReduced,
	output logic             lpsWurDisable,
	output logic             sleepAckTimerEn,
	output logic             sleepAllowed,
	output logic             returnToNormal,
	output logic             localWakeEvent,
	output logic             localWakeFwd,
	output logic             remoteWakeEvent,
	output logic             remoteWakeFwd
);
	logic [15:0] cfgReg, cfgNext;
	logic        strapDoneReg, strapDoneNext;
	logic [15:0] cntReg, cntNext;
	logic        locLevelReg, locLevelNext;
	logic        prevLocReact;
	pwmc_pkg::pwmc_arm_t armReg, armNext;
	logic        wakeSync;
	logic        remSync;
	logic [15:0] strapVal;

	initial begin
		if (WAKE_DET_CYC < 1 || WAKE_DET_CYC > 65535)
			$error("pwmc_config_reg: WAKE_DET_CYC out of range");
	end

	pwmc_sync3 #(.WIDTH(1)) uLocSync (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (localWakePin),
		.dout (wakeSync)
	);
	pwmc_sync3 #(.WIDTH(1)) uRemSync (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (remoteWakeRx),
		.dout (remSync)
	);

	// Strap-derived reset image; wake bits follow one strap level
	always_comb begin
		strapVal = `PWMC_RESET_FIXED;
		strapVal[`PWMC_BIT_ROLE]      = strapRole;
		strapVal[`PWMC_BIT_LOC_FWD]   = strapWakeEn;
		strapVal[`PWMC_BIT_REM_REACT] = strapWakeEn;
		strapVal[`PWMC_BIT_LOC_REACT] = strapWakeEn;
		strapVal[`PWMC_BIT_REM_FWD]   = strapWakeEn;
		strapVal[`PWMC_MII_HI:`PWMC_MII_LO] = strapIface;
	end

	// Straps caught once, at the first enabled edge after reset release
	always_comb begin
		strapDoneNext = 1'b1;
		cfgNext = cfgReg;
		if (!strapDoneReg) begin
			cfgNext = strapVal;
		end else if (regWrite && regAddr == `PWMC_REG_ADDR) begin
			// Reserved bits and low bits outside this block are kept as is
			cfgNext = (regWdata & `PWMC_WRITE_MASK)
				| (cfgReg & ~`PWMC_WRITE_MASK);
		end
	end

	// Local wake arming: a pin change right after enabling may be missed
	always_comb begin
		armNext = armReg;
		cntNext = cntReg;
		locLevelNext = wakeSync;
		case (armReg)
			pwmc_pkg::PWMC_ARM_IDLE: begin
				if (cfgReg[`PWMC_BIT_LOC_REACT]) begin
					armNext = pwmc_pkg::PWMC_ARM_WAIT;
					cntNext = 16'(WAKE_DET_CYC - 1);
				end
			end
			pwmc_pkg::PWMC_ARM_WAIT: begin
				if (!cfgReg[`PWMC_BIT_LOC_REACT]) begin
					armNext = pwmc_pkg::PWMC_ARM_IDLE;
				end else if (cntReg == 16'h0000) begin
					armNext = pwmc_pkg::PWMC_ARM_LIVE;
				end else begin
					cntNext = cntReg - 16'h0001;
				end
			end
			pwmc_pkg::PWMC_ARM_LIVE: begin
				if (!cfgReg[`PWMC_BIT_LOC_REACT]) armNext = pwmc_pkg::PWMC_ARM_IDLE;
			end
			default: armNext = pwmc_pkg::PWMC_ARM_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgReg       <= `PWMC_RESET_FIXED;
			strapDoneReg <= 1'b0;
			armReg       <= pwmc_pkg::PWMC_ARM_IDLE;
			cntReg       <= 16'h0000;
			locLevelReg  <= 1'b0;
		end else if (ce) begin
			cfgReg       <= cfgNext;
			strapDoneReg <= strapDoneNext;
			armReg       <= armNext;
			cntReg       <= cntNext;
			locLevelReg  <= locLevelNext;
		end
	end

	assign prevLocReact = armReg == pwmc_pkg::PWMC_ARM_LIVE;
	assign regRdata = cfgReg;

	assign roleMaster     = cfgReg[`PWMC_BIT_ROLE];
	assign hostIfaceSel   = cfgReg[`PWMC_MII_HI:`PWMC_MII_LO];
	assign refClkIsOutput = cfgReg[`PWMC_MII_HI:`PWMC_MII_LO]
		== pwmc_pkg::PWMC_RMII_CLK_OUT;
	assign driveReduced   = cfgReg[`PWMC_BIT_DRIVE];
	assign lpsWurDisable  = cfgReg[`PWMC_BIT_LPS_DIS];
	assign sleepAckTimerEn = cfgReg[`PWMC_BIT_ACK];
	// Peer confirmation gates sleep only when requested
	assign sleepAllowed   = !cfgReg[`PWMC_BIT_CONFIRM] || peerSleepConfirm;
	assign returnToNormal = sleepReqMode && dataActivity
		&& !cfgReg[`PWMC_BIT_ACK];
	// Rising edge of the filtered pin, only once armed
	assign localWakeEvent = prevLocReact && wakeSync && !locLevelReg;
	assign localWakeFwd   = localWakeEvent && cfgReg[`PWMC_BIT_LOC_FWD];
	assign remoteWakeEvent = remSync && cfgReg[`PWMC_BIT_REM_REACT];
	assign remoteWakeFwd  = remoteWakeEvent && cfgReg[`PWMC_BIT_REM_FWD];

	AST_ROLE: assert property (@(posedge clk) disable iff (!rst_n)
		roleMaster == regRdata[15]) else $error("role output mismatch");
	AST_LFWD: assert property (@(posedge clk) disable iff (!rst_n)
		localWakeFwd |-> cfgReg[14] && localWakeEvent) else $error("bad local fwd");
	AST_RREACT: assert property (@(posedge clk) disable iff (!rst_n)
		!cfgReg[11] |-> !remoteWakeEvent) else $error("remote wake not gated");
	AST_LREACT: assert property (@(posedge clk) disable iff (!rst_n)
		!cfgReg[10] |-> !localWakeEvent) else $error("local wake not gated");
	AST_IFACE: assert property (@(posedge clk) disable iff (!rst_n)
		refClkIsOutput == (hostIfaceSel == 2'h2)) else $error("ref clk dir wrong");
	AST_CONFIRM: assert property (@(posedge clk) disable iff (!rst_n)
		cfgReg[6] && !peerSleepConfirm |-> !sleepAllowed) else $error("sleep w/o confirm");
	AST_RETURN: assert property (@(posedge clk) disable iff (!rst_n)
		sleepReqMode && dataActivity |-> returnToNormal == !cfgReg[4]) else $error("return");
	AST_RFWD: assert property (@(posedge clk) disable iff (!rst_n)
		remoteWakeFwd |-> cfgReg[2] && cfgReg[11]) else $error("bad remote fwd");
	AST_ARM: assert property (@(posedge clk) disable iff (!rst_n)
		ce && $rose(cfgReg[10]) |-> !localWakeEvent) else $error("wake before arm");
	sequence armDone;
		ce && armReg == pwmc_pkg::PWMC_ARM_WAIT && cntReg == 16'h0000 && cfgReg[10];
	endsequence
	AST_ARM_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
		armDone |=> prevLocReact) else $error("arming did not complete");
	AST_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
		$past(strapDoneReg) |-> cfgReg[13:12] == 2'h0 && !cfgReg[3]) else $error("rsvd");
endmodule : pwmc_config_reg
`default_nettype wire

/* design/pwmc_cfg.svh */
`ifndef PWMC_CFG_SVH
`define PWMC_CFG_SVH
// Overview of operation
// - Bit 15 selects role, 0 slave, 1 master.
// - Bit 14 enables local forwarding of detected wake-up events.
// - Bit 11 enables reaction to remote wake-up from the bus.
// - Bit 10 enables reaction to the local wake-up input.
// - Bits 9:8 select MII, RMII clock in, RMII clock out, reverse MII.
// - Bit 7 sets host drive strength, 0 standard, 1 reduced; resets 0.
// - Bit 6 set requires peer confirmation before sleep; resets 0.
// - Bit 4 clear: ack timer off, data activity returns to Normal.
// - Bit 4 set: ack timer on, data activity does not return.
// - Bit 2 clear blocks remote wake forwarding; reset value comes from the wake strap.
// - Bit 2 set forwards a received remote wake-up event.
// - Role, wake and interface select reset values come from strap pins.
// - Local wake detection arms only after the wake detection time.
`define PWMC_REG_ADDR        5'h12
`define PWMC_BIT_ROLE        15
`define PWMC_BIT_LOC_FWD     14
`define PWMC_BIT_REM_REACT   11
`define PWMC_BIT_LOC_REACT   10
`define PWMC_MII_HI          9
`define PWMC_MII_LO          8
`define PWMC_BIT_DRIVE       7
`define PWMC_BIT_CONFIRM     6
`define PWMC_BIT_LPS_DIS     5
`define PWMC_BIT_ACK         4
`define PWMC_BIT_REM_FWD     2
`define PWMC_WRITE_MASK      16'hcff4
`define PWMC_RESET_FIXED     16'h0001
`define PWMC_WAKE_DET_NS     1000
`define PWMC_CLK_PERIOD_NS   10
`define PWMC_WAKE_DET_CYC    ((`PWMC_WAKE_DET_NS + `PWMC_CLK_PERIOD_NS - 1) / `PWMC_CLK_PERIOD_NS)
`endif

/* design/pwmc_pkg.sv */
package pwmc_pkg;
	typedef enum logic [1:0] {
		PWMC_MII_NORMAL,
		PWMC_RMII_CLK_IN,
		PWMC_RMII_CLK_OUT,
		PWMC_MII_REVERSE
	} pwmc_iface_t;
	typedef enum {PWMC_ARM_IDLE, PWMC_ARM_WAIT, PWMC_ARM_LIVE} pwmc_arm_t;
endpackage : pwmc_pkg

/* design/pwmc_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module pwmc_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1Reg, s2Reg, s3Reg, outReg;
	logic [WIDTH-1:0] s1Next, s2Next, s3Next, outNext;
	initial begin
		if (WIDTH < 1) $error("pwmc_sync3: WIDTH must be positive");
	end
	// First stage is read only by the second stage
	always_comb begin
		s1Next  = din;
		s2Next  = s1Reg;
		s3Next  = s2Reg;
		outNext = (s2Reg == s3Reg) ? s3Reg : outReg;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1Reg  <= '0;
			s2Reg  <= '0;
			s3Reg  <= '0;
			outReg <= '0;
		end else if (ce) begin
			s1Reg  <= s1Next;
			s2Reg  <= s2Next;
			s3Reg  <= s3Next;
			outReg <= outNext;
		end
	end
	assign dout = outReg;
endmodule : pwmc_sync3
`default_nettype wire

/* bench/phy_wake_mii_config_reg_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_cfg.svh"
module phy_wake_mii_config_reg_tb;
	// Short arming time keeps the run brief; expectations follow it
	localparam int DET = 20;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic [4:0]  regAddr = 5'h00;
	logic        regWrite = 1'b0;
	logic [15:0] regWdata = 16'h0000;
	logic [15:0] regRdata;
	logic        localWakePin = 1'b0;
	logic        remoteWakeRx = 1'b0;
	logic        sleepReqMode = 1'b0;
	logic        dataActivity = 1'b0;
	logic        peerSleepConfirm = 1'b0;
	logic        roleMaster, refClkIsOutput, driveReduced, lpsWurDisable;
	logic        sleepAckTimerEn, sleepAllowed, returnToNormal;
	logic        localWakeEvent, localWakeFwd, remoteWakeEvent, remoteWakeFwd;
	logic [1:0]  hostIfaceSel;
	logic        seenEv, seenFwd;
	int          fails = 0;
	int          tests_run = 0;
	always #5 clk = ~clk;
	pwmc_config_reg #(.WAKE_DET_CYC(DET)) pwmc_config_reg_inst (
		.clk(clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWrite(regWrite),
		.regWdata(regWdata), .regRdata(regRdata), .strapRole(1'b1), .strapWakeEn(1'b1),
		.strapIface(2'b10), .localWakePin(localWakePin), .remoteWakeRx(remoteWakeRx),
		.sleepReqMode(sleepReqMode), .dataActivity(dataActivity),
		.peerSleepConfirm(peerSleepConfirm), .roleMaster(roleMaster),
		.hostIfaceSel(hostIfaceSel), .refClkIsOutput(refClkIsOutput),
		.driveReduced(driveReduced), .lpsWurDisable(lpsWurDisable),
		.sleepAckTimerEn(sleepAckTimerEn), .sleepAllowed(sleepAllowed),
		.returnToNormal(returnToNormal), .localWakeEvent(localWakeEvent),
		.localWakeFwd(localWakeFwd), .remoteWakeEvent(remoteWakeEvent),
		.remoteWakeFwd(remoteWakeFwd));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask : wr
	// Pulses last one cycle, so every edge in the span is looked at
	task automatic watch(input int n);
		seenEv = 1'b0;
		seenFwd = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (localWakeEvent === 1'b1) seenEv = 1'b1;
			if (localWakeFwd === 1'b1) seenFwd = 1'b1;
		end
	endtask : watch
	task automatic localTry(input logic [15:0] d, input logic ev, input logic fw);
		wr(`PWMC_REG_ADDR, d);
		repeat (DET + 4) @(negedge clk);
		localWakePin = 1'b1;
		watch(12);
		localWakePin = 1'b0;
		chk("local event", 16'(ev), 16'(seenEv));
		chk("local fwd", 16'(fw), 16'(seenFwd));
	endtask : localTry
	task automatic wrap_up();
		if (fails == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		#100000;
		fails++;
		wrap_up();
	end
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("strap value", 16'hce05, regRdata);
		chk("strap iface", 16'h0002, 16'(hostIfaceSel));
		wr(`PWMC_REG_ADDR, 16'hffff);
		chk("all ones", 16'hcff5, regRdata);
		chk("master", 16'h0001, 16'(roleMaster));
		chk("drive reduced", 16'h0001, 16'(driveReduced));
		chk("lps wur disable", 16'h0001, 16'(lpsWurDisable));
		wr(5'h11, 16'h0000);
		chk("other address", 16'hcff5, regRdata);
		wr(`PWMC_REG_ADDR, 16'h0000);
		chk("all zeros", 16'h0001, regRdata);
		chk("slave", 16'h0000, 16'(roleMaster));
		chk("drive standard", 16'h0000, 16'(driveReduced));
		chk("lps wur enable", 16'h0000, 16'(lpsWurDisable));
		// Clock enable low must freeze the register against a write
		ce = 1'b0;
		wr(`PWMC_REG_ADDR, 16'hffff);
		chk("frozen role", 16'h0000, 16'(roleMaster));
		ce = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(`PWMC_REG_ADDR, {6'h00, 2'(i), 8'h00});
			chk("iface", 16'(i), 16'(hostIfaceSel));
			chk("refclk out", 16'(i == 2), 16'(refClkIsOutput));
		end
		sleepReqMode = 1'b1;
		dataActivity = 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(`PWMC_REG_ADDR, {9'h000, k[0], 1'b0, k[1], 4'h0});
			chk("sleep no peer", 16'(!k[0]), 16'(sleepAllowed));
			chk("return normal", 16'(!k[1]), 16'(returnToNormal));
			chk("ack timer", 16'(k[1]), 16'(sleepAckTimerEn));
			peerSleepConfirm = 1'b1;
			#1;
			chk("sleep peer", 16'h0001, 16'(sleepAllowed));
			peerSleepConfirm = 1'b0;
		end
		for (int k = 0; k < 4; k++) begin
			wr(`PWMC_REG_ADDR, {4'h0, k[1], 8'h00, k[0], 2'h0});
			remoteWakeRx = 1'b1;
			repeat (8) @(negedge clk);
			chk("remote event", 16'(k[1]), 16'(remoteWakeEvent));
			chk("remote fwd", 16'(k[1] & k[0]), 16'(remoteWakeFwd));
			remoteWakeRx = 1'b0;
			repeat (8) @(negedge clk);
		end
		// A wake right after arming falls inside the blind interval
		wr(`PWMC_REG_ADDR, 16'h4400);
		localWakePin = 1'b1;
		watch(8);
		localWakePin = 1'b0;
		chk("early wake", 16'h0000, 16'(seenEv));
		localTry(16'h4400, 1'b1, 1'b1);
		localTry(16'h0400, 1'b1, 1'b0);
		localTry(16'h4000, 1'b0, 1'b0);
		wrap_up();
	end
endmodule : phy_wake_mii_config_reg_tb
`default_nettype wire
